// [hdl/mtoc_pkg.sv]
package mtoc_pkg;
   // ------------------------------------------------------------
   // trigger output modes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MTOC_TRIG_DONE   = 3'h0,
      MTOC_TRIG_RATE   = 3'h1,
      MTOC_TRIG_THRESH = 3'h2,
      MTOC_TRIG_ENERGY = 3'h3,
      MTOC_TRIG_OFF    = 3'h4
   } mtoc_trig_mode_t;

   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MTOC_CMD_NONE      = 4'h0,
      MTOC_CMD_SET_MODE  = 4'h1,
      MTOC_CMD_SET_RATE  = 4'h2,
      MTOC_CMD_SET_LVL   = 4'h3,
      MTOC_CMD_SET_ELIM  = 4'h4,
      MTOC_CMD_SET_POL   = 4'h5,
      MTOC_CMD_STOP_ALL  = 4'h6,
      MTOC_CMD_STOP_CH   = 4'h7,
      MTOC_CMD_CAP_REF   = 4'h8,
      MTOC_CMD_CAP_ZERO  = 4'h9,
      MTOC_CMD_SET_TONE  = 4'hA,
      MTOC_CMD_SET_DEPTH = 4'hB,
      MTOC_CMD_SET_UNITS = 4'hC,
      MTOC_CMD_SET_ZEN   = 4'hD,
      MTOC_CMD_SET_ACQ   = 4'hE
   } mtoc_cmd_t;

   // ------------------------------------------------------------
   // widths, limits, timing
   // ------------------------------------------------------------
   localparam int          MTOC_DW          = 32;
   localparam int          MTOC_PW          = 40;
   localparam logic [6:0]  MTOC_DEPTH_MAX   = 7'h64;
   localparam logic [3:0]  MTOC_UNITS_MAX   = 4'hA;
   localparam logic [1:0]  MTOC_TONE_NA     = 2'h3;
   localparam int          MTOC_CLK_HZ      = 125000000;
   localparam int          MTOC_TICK_NS     = 1000000;
   localparam int          MTOC_CLK_NS      = 8;
   localparam int          MTOC_TICK_CYC    = (MTOC_TICK_NS + MTOC_CLK_NS - 1) / MTOC_CLK_NS;
   localparam int          MTOC_PULSE_NS    = 1000;
   localparam int          MTOC_PULSE_CYC   = MTOC_PULSE_NS / MTOC_CLK_NS;
   localparam logic [MTOC_PW-1:0] MTOC_RATE_RST = 40'h0007735940;
   localparam logic        MTOC_POL_RST     = 1'b1;
   localparam logic [6:0]  MTOC_DEPTH_RST   = 7'h00;
   localparam logic [3:0]  MTOC_UNITS_RST   = 4'h2;
endpackage : mtoc_pkg

// [hdl/mtoc_top.sv]
// Summary of operation
// - trigger output has five selectable modes
// - rate mode pulses at programmed period
// - threshold mode active while reading >= threshold
// - energy mode inactive once energy reaches limit
// - polarity bit chooses active level, reads back
// - mode query returns the current mode code
// - global stop ends acquisition on both channels
// - channel stop ends only addressed channel
// - capture reference copies latest channel reading
// - reference readback shows last captured value
// - capture zero copies latest reading to offset
// - tone ticks on peaks only when enabled and in peak mode
// - tone enable without support flags an error
// - tone readback: unavailable, off or on
// - depth readback returns channel depth 0..100
// - units accepted from eleven codes per channel
// - buffer clear on depth, acquisition, units change
// - zeroing subtracts offset from incoming readings
`timescale 1ns/1ps
module mtoc_top (
   // clock and reset
   input  wire logic                         i_clock,
   input  wire logic                         i_reset,
   // command port, one-cycle strobe
   input  wire logic                         i_cmd_valid,
   input  wire logic [3:0]                   i_cmd_code,
   input  wire logic                         i_cmd_chan,
   input  wire logic [mtoc_pkg::MTOC_PW-1:0] i_cmd_arg,
   // measurement side
   input  wire logic [1:0]                   i_sample_valid,
   input  wire logic [mtoc_pkg::MTOC_DW-1:0] i_sample_a,
   input  wire logic [mtoc_pkg::MTOC_DW-1:0] i_sample_b,
   input  wire logic [mtoc_pkg::MTOC_DW-1:0] i_energy_a,
   input  wire logic [1:0]                   i_acq_start,
   input  wire logic [1:0]                   i_peak_seen,
   input  wire logic                         i_peak_mode,
   input  wire logic                         i_tone_supported,
   // trigger and tone pins
   output logic                              o_trigger_out,
   output logic                              o_tone_tick,
   // status and readback
   output logic [2:0]                        o_trigger_mode,
   output logic                              o_trigger_polarity,
   output logic [1:0]                        o_acquiring,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_reference_a,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_reference_b,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_zero_offset_a,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_zero_offset_b,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_corrected_a,
   output logic [mtoc_pkg::MTOC_DW-1:0]      o_corrected_b,
   output logic [1:0]                        o_tone_state,
   output logic                              o_cmd_error,
   output logic [6:0]                        o_depth_a,
   output logic [6:0]                        o_depth_b,
   output logic [3:0]                        o_units_a,
   output logic [3:0]                        o_units_b,
   output logic [1:0]                        o_stats_clear
);
   localparam int DW = mtoc_pkg::MTOC_DW;
   localparam int PW = mtoc_pkg::MTOC_PW;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire logic cmd_mode  = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_MODE;
   wire logic cmd_rate  = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_RATE;
   wire logic cmd_lvl   = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_LVL;
   wire logic cmd_elim  = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_ELIM;
   wire logic cmd_pol   = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_POL;
   wire logic cmd_stopa = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_STOP_ALL;
   wire logic cmd_stopc = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_STOP_CH;
   wire logic cmd_cref  = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_CAP_REF;
   wire logic cmd_czero = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_CAP_ZERO;
   wire logic cmd_tone  = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_TONE;
   wire logic cmd_depth = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_DEPTH;
   wire logic cmd_units = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_UNITS;
   wire logic cmd_zen   = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_ZEN;
   wire logic cmd_acq   = i_cmd_valid && i_cmd_code == mtoc_pkg::MTOC_CMD_SET_ACQ;
   wire logic [1:0] ch_sel = i_cmd_chan ? 2'h2 : 2'h1;

   function automatic logic [1:0] chan_hit(input logic hit, input logic [1:0] sel);
      chan_hit = hit ? sel : 2'h0;
   endfunction : chan_hit

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   mtoc_pkg::mtoc_trig_mode_t mode_r;
   logic [PW-1:0] rate_r;
   logic [DW-1:0] lvl_r;
   logic [DW-1:0] elim_r;
   logic          pol_r;
   logic          tone_en_r;
   logic [1:0]    zen_r;
   logic [DW-1:0] latest_r   [2];
   logic [DW-1:0] zero_r     [2];
   logic [DW-1:0] ref_r      [2];
   logic [6:0]    depth_r    [2];
   logic [3:0]    units_r    [2];
   logic [1:0]    acq_r;
   logic [1:0]    clear_r;
   logic          err_r;

   wire logic mode_ok = i_cmd_arg[2:0] <= 3'(mtoc_pkg::MTOC_TRIG_OFF);
   wire logic [6:0] depth_arg = (i_cmd_arg[6:0] > mtoc_pkg::MTOC_DEPTH_MAX) ?
                                mtoc_pkg::MTOC_DEPTH_MAX : i_cmd_arg[6:0];
   wire logic units_ok = i_cmd_arg[3:0] <= mtoc_pkg::MTOC_UNITS_MAX;
   wire logic rate_ok  = i_cmd_arg != '0;
   // the host passes the polarity value unchanged; only bit 0 is kept
   wire logic [1:0] stop_hit = (cmd_stopa ? 2'h3 : 2'h0) | chan_hit(cmd_stopc, ch_sel);
   wire logic [1:0] units_hit = chan_hit(cmd_units && units_ok, ch_sel);
   wire logic [1:0] depth_hit = chan_hit(cmd_depth, ch_sel);
   wire logic [1:0] acq_hit   = chan_hit(cmd_acq, ch_sel);

   // zero capture takes the raw reading so the offset never compounds
   logic [DW-1:0] raw_last_r [2];
   function automatic logic [DW-1:0] raw_latest(input int c);
      raw_latest = raw_last_r[c];
   endfunction : raw_latest

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         mode_r    <= mtoc_pkg::MTOC_TRIG_OFF;
         rate_r    <= mtoc_pkg::MTOC_RATE_RST;
         lvl_r     <= '0;
         elim_r    <= '0;
         pol_r     <= mtoc_pkg::MTOC_POL_RST;
         tone_en_r <= 1'b0;
         zen_r     <= 2'h0;
         err_r     <= 1'b0;
      end else begin
         if (cmd_mode && mode_ok)
            mode_r <= mtoc_pkg::mtoc_trig_mode_t'(i_cmd_arg[2:0]);
         if (cmd_rate && rate_ok)
            rate_r <= i_cmd_arg;
         if (cmd_lvl)
            lvl_r <= i_cmd_arg[DW-1:0];
         if (cmd_elim)
            elim_r <= i_cmd_arg[DW-1:0];
         if (cmd_pol)
            pol_r <= i_cmd_arg[0];
         if (cmd_tone && i_tone_supported)
            tone_en_r <= i_cmd_arg[0];
         if (cmd_zen)
            zen_r[i_cmd_chan] <= i_cmd_arg[0];
         err_r <= cmd_tone && !i_tone_supported;
      end
   end

   // ------------------------------------------------------------
   // per-channel acquisition, capture and buffer control
   // ------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      wire logic [DW-1:0] raw = (c == 0) ? i_sample_a : i_sample_b;
      wire logic [DW-1:0] cor = zen_r[c] ? raw - zero_r[c] : raw;
      always_ff @(posedge i_clock) begin
         if (i_reset) begin
            acq_r[c]    <= 1'b0;
            latest_r[c] <= '0;
            zero_r[c]   <= '0;
            ref_r[c]    <= '0;
            depth_r[c]  <= mtoc_pkg::MTOC_DEPTH_RST;
            units_r[c]  <= mtoc_pkg::MTOC_UNITS_RST;
            clear_r[c]  <= 1'b0;
         end else begin
            // stop wins over a start in the same cycle; idle stays idle
            if (stop_hit[c])
               acq_r[c] <= 1'b0;
            else if (i_acq_start[c])
               acq_r[c] <= 1'b1;
            if (i_sample_valid[c])
               latest_r[c] <= cor;
            if (cmd_cref && ch_sel[c])
               ref_r[c] <= latest_r[c];
            if (cmd_czero && ch_sel[c])
               zero_r[c] <= raw_latest(c);
            if (depth_hit[c])
               depth_r[c] <= depth_arg;
            if (units_hit[c])
               units_r[c] <= i_cmd_arg[3:0];
            clear_r[c] <= depth_hit[c] || acq_hit[c] ||
                          (units_hit[c] && i_cmd_arg[3:0] != units_r[c]);
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         raw_last_r[0] <= '0;
         raw_last_r[1] <= '0;
      end else begin
         if (i_sample_valid[0])
            raw_last_r[0] <= i_sample_a;
         if (i_sample_valid[1])
            raw_last_r[1] <= i_sample_b;
      end
   end

   // ------------------------------------------------------------
   // trigger generation
   // ------------------------------------------------------------
   logic [$clog2(mtoc_pkg::MTOC_TICK_CYC)-1:0] tick_cnt_r;
   logic [PW-1:0]  period_cnt_r;
   logic [7:0]     pulse_cnt_r;
   logic           active_r;
   wire logic tick = tick_cnt_r == '0;
   wire logic mode_chg = cmd_mode && mode_ok;
   // period counted in ms ticks: slow rates need a wide counter, not fine steps
   wire logic period_end = tick && period_cnt_r <= 40'h1;
   wire logic fire = (mode_r == mtoc_pkg::MTOC_TRIG_DONE && |i_sample_valid) ||
                     (mode_r == mtoc_pkg::MTOC_TRIG_RATE && period_end);

   always_ff @(posedge i_clock) begin
      if (i_reset || mode_chg) begin
         tick_cnt_r   <= '0;
         period_cnt_r <= '0;
         pulse_cnt_r  <= '0;
      end else begin
         tick_cnt_r <= tick ? ($bits(tick_cnt_r))'(mtoc_pkg::MTOC_TICK_CYC - 1)
                            : tick_cnt_r - 1'b1;
         if (period_end)
            period_cnt_r <= rate_r;
         else if (tick)
            period_cnt_r <= period_cnt_r - 1'b1;
         if (fire)
            pulse_cnt_r <= 8'(mtoc_pkg::MTOC_PULSE_CYC);
         else if (pulse_cnt_r != '0)
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
      end
   end

   always_comb begin
      case (mode_r)
         mtoc_pkg::MTOC_TRIG_DONE:   active_r = pulse_cnt_r != '0;
         mtoc_pkg::MTOC_TRIG_RATE:   active_r = pulse_cnt_r != '0;
         mtoc_pkg::MTOC_TRIG_THRESH: active_r = latest_r[0] >= lvl_r;
         mtoc_pkg::MTOC_TRIG_ENERGY: active_r = i_energy_a < elim_r;
         default:                    active_r = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_trigger_out <= !mtoc_pkg::MTOC_POL_RST;
         o_tone_tick   <= 1'b0;
      end else begin
         o_trigger_out <= pol_r ? active_r : !active_r;
         o_tone_tick   <= tone_en_r && i_peak_mode && |i_peak_seen;
      end
   end

   always_ff @(posedge i_clock) begin
      o_trigger_mode     <= mode_r;
      o_trigger_polarity <= pol_r;
      o_acquiring        <= acq_r;
      o_reference_a      <= ref_r[0];
      o_reference_b      <= ref_r[1];
      o_zero_offset_a    <= zero_r[0];
      o_zero_offset_b    <= zero_r[1];
      o_corrected_a      <= latest_r[0];
      o_corrected_b      <= latest_r[1];
      o_tone_state       <= i_tone_supported ? {1'b0, tone_en_r} : mtoc_pkg::MTOC_TONE_NA;
      o_cmd_error        <= err_r;
      o_depth_a          <= depth_r[0];
      o_depth_b          <= depth_r[1];
      o_units_a          <= units_r[0];
      o_units_b          <= units_r[1];
      o_stats_clear      <= clear_r;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_stop_cmd;
      cmd_stopa;
   endsequence

   a_global_stop_idle: assert property (@(posedge i_clock) disable iff (i_reset)
      s_stop_cmd |=> acq_r == 2'h0) else $error("global stop left a channel running");
   a_chan_stop_only: assert property (@(posedge i_clock) disable iff (i_reset)
      cmd_stopc && !cmd_stopa |=> acq_r[!$past(i_cmd_chan)] == ($past(acq_r[!i_cmd_chan]) ||
      $past(i_acq_start[!i_cmd_chan]))) else $error("channel stop hit the other channel");
   a_ref_capture: assert property (@(posedge i_clock) disable iff (i_reset)
      cmd_cref && !i_cmd_chan |=> ##1 o_reference_a == $past(latest_r[0], 2))
      else $error("reference capture wrong");
   a_tone_error: assert property (@(posedge i_clock) disable iff (i_reset)
      cmd_tone && !i_tone_supported |=> err_r ##1 o_cmd_error)
      else $error("tone error not flagged");
   a_off_inactive: assert property (@(posedge i_clock) disable iff (i_reset)
      mode_r == mtoc_pkg::MTOC_TRIG_OFF && !cmd_pol |=> o_trigger_out == !$past(pol_r))
      else $error("off mode drove active level");
   a_done_pulse: assert property (@(posedge i_clock) disable iff (i_reset)
      mode_r == mtoc_pkg::MTOC_TRIG_DONE && !mode_chg && |i_sample_valid |=> ##1
      o_trigger_out == $past(pol_r)) else $error("conversion pulse missing");
   a_depth_clear: assert property (@(posedge i_clock) disable iff (i_reset)
      cmd_depth |=> clear_r[$past(i_cmd_chan)] ##1 o_stats_clear != 2'h0)
      else $error("buffer clear missing");
   a_depth_bound: assert property (@(posedge i_clock) disable iff (i_reset)
      o_depth_a <= mtoc_pkg::MTOC_DEPTH_MAX && o_depth_b <= mtoc_pkg::MTOC_DEPTH_MAX)
      else $error("depth out of range");
   a_tone_na: assert property (@(posedge i_clock) disable iff (i_reset)
      !i_tone_supported |=> o_tone_state == mtoc_pkg::MTOC_TONE_NA)
      else $error("tone state not unavailable");
endmodule : mtoc_top

// [verification/meter_trigger_output_control_test.sv]
`timescale 1ns/1ps
module meter_trigger_output_control_test;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst, go, rogue, chan, cv, cch, pk_mode, tone_ok, trig, tick, pol, err;
   logic [3:0]  code, ccode, un_a, un_b;
   logic [39:0] arg, carg;
   logic [1:0]  s_vld, acq, peak, acqing, tstate, clr;
   logic [31:0] s_a, s_b, en_a, ref_a, ref_b, zo_a, zo_b, cor_a, cor_b, r1, r2;
   logic [2:0]  mode;
   logic [6:0]  dep_a, dep_b, dv;
   logic [3:0]  exp_q[$];
   logic [31:0] lfsr = 32'h45;
   int          num_errors = 0;
   int          cmp_count = 0;

   always #4 clk = ~clk;

   mtoc_host_model i_host (.i_clock(clk), .i_go(go), .i_rogue(rogue), .i_code(code),
      .i_chan(chan), .i_arg(arg), .o_cmd_valid(cv), .o_cmd_code(ccode),
      .o_cmd_chan(cch), .o_cmd_arg(carg));

   mtoc_top i_dut (.i_clock(clk), .i_reset(rst), .i_cmd_valid(cv), .i_cmd_code(ccode),
      .i_cmd_chan(cch), .i_cmd_arg(carg), .i_sample_valid(s_vld), .i_sample_a(s_a),
      .i_sample_b(s_b), .i_energy_a(en_a), .i_acq_start(acq), .i_peak_seen(peak),
      .i_peak_mode(pk_mode), .i_tone_supported(tone_ok), .o_trigger_out(trig),
      .o_tone_tick(tick), .o_trigger_mode(mode), .o_trigger_polarity(pol),
      .o_acquiring(acqing), .o_reference_a(ref_a), .o_reference_b(ref_b),
      .o_zero_offset_a(zo_a), .o_zero_offset_b(zo_b), .o_corrected_a(cor_a),
      .o_corrected_b(cor_b), .o_tone_state(tstate), .o_cmd_error(err),
      .o_depth_a(dep_a), .o_depth_b(dep_b), .o_units_a(un_a), .o_units_b(un_b),
      .o_stats_clear(clr));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_evt(input logic [3:0] got);
      logic [3:0] exp;
      exp = (exp_q.size() > 0) ? exp_q.pop_front() : 4'h0;
      chk_val(32'(got), 32'(exp));
   endtask : chk_evt

   task automatic cmd(input logic [3:0] c, input logic ch, input logic [39:0] a);
      @(posedge clk);
      go   <= 1'b1;
      code <= c;
      chan <= ch;
      arg  <= a;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : cmd

   // the sample lines flip after the strobe, as a released source would leave them
   task automatic smp(input logic ch, input logic [31:0] v);
      @(posedge clk);
      s_vld[ch] <= 1'b1;
      if (ch) s_b <= v; else s_a <= v;
      @(posedge clk);
      s_vld <= 2'h0;
      s_a   <= ~s_a;
      s_b   <= ~s_b;
      repeat (3) @(posedge clk);
      #1;
   endtask : smp

   task automatic strobe(input logic is_peak);
      @(posedge clk);
      if (is_peak) peak <= lfsr[0] ? 2'h2 : 2'h1; else acq <= 2'h3;
      @(posedge clk);
      peak <= 2'h0;
      acq  <= 2'h0;
      repeat (3) @(posedge clk);
      #1;
   endtask : strobe

   // ------------------------------------------------------------
   // result watcher: each pulse takes the oldest note
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst && ({err, clr, tick} !== 4'h0)) chk_evt({err, clr, tick});
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, go, rogue, chan, code, arg, s_vld, acq, peak} = {1'b1, 53'h0};
      {s_a, s_b, en_a, pk_mode, tone_ok} = {96'h0, 2'h0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_val(32'(mode), 32'(mtoc_pkg::MTOC_TRIG_OFF));
      chk_val(32'({pol, trig, tstate, acqing}), 32'h2C);
      chk_val(32'({un_a, dep_a}), 32'h100);
      $display("reset test done");
      for (int m = 0; m < 5; m++) begin
         cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'(m));
         chk_val(32'(mode), 32'(m));
      end
      cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'h7);
      chk_val(32'(mode), 32'h4);
      cmd(mtoc_pkg::MTOC_CMD_SET_POL, 1'b0, 40'h0);
      chk_val(32'({pol, trig}), 32'h1);
      cmd(mtoc_pkg::MTOC_CMD_SET_POL, 1'b0, 40'h1);
      chk_val(32'({pol, trig}), 32'h2);
      $display("mode test done");
      strobe(1'b0);
      chk_val(32'(acqing), 32'h3);
      for (int k = 0; k < 2; k++) begin
         cmd(mtoc_pkg::MTOC_CMD_STOP_CH, 1'b0, 40'h0);
         chk_val(32'(acqing), 32'h2);
      end
      for (int k = 0; k < 2; k++) begin
         cmd(mtoc_pkg::MTOC_CMD_STOP_ALL, 1'b0, 40'h0);
         chk_val(32'(acqing), 32'h0);
      end
      $display("stop test done");
      exp_q.push_back(4'h8);
      cmd(mtoc_pkg::MTOC_CMD_SET_TONE, 1'b0, 40'h1);
      chk_val(32'(tstate), 32'h3);
      @(posedge clk);
      tone_ok <= 1'b1;
      pk_mode <= 1'b1;
      cmd(mtoc_pkg::MTOC_CMD_SET_TONE, 1'b0, 40'h1);
      chk_val(32'(tstate), 32'h1);
      exp_q.push_back(4'h1);
      strobe(1'b1);
      // outside peak modes an enabled tone stays silent
      @(posedge clk);
      pk_mode <= 1'b0;
      strobe(1'b1);
      cmd(mtoc_pkg::MTOC_CMD_SET_TONE, 1'b0, 40'h0);
      chk_val(32'(tstate), 32'h0);
      strobe(1'b1);
      $display("tone test done");
      lfsr = lfsr_next(lfsr);
      dv = lfsr[6:0];
      exp_q.push_back(4'h2);
      cmd(mtoc_pkg::MTOC_CMD_SET_DEPTH, 1'b0, 40'(dv));
      chk_val(32'(dep_a), (dv > 7'h64) ? 32'h64 : 32'(dv));
      exp_q.push_back(4'h4);
      cmd(mtoc_pkg::MTOC_CMD_SET_DEPTH, 1'b1, 40'h65);
      chk_val(32'(dep_b), 32'h64);
      for (int u = 0; u < 11; u++) begin
         exp_q.push_back(4'h2);
         cmd(mtoc_pkg::MTOC_CMD_SET_UNITS, 1'b0, 40'(u));
         chk_val(32'(un_a), 32'(u));
      end
      rogue = 1'b1;
      cmd(mtoc_pkg::MTOC_CMD_SET_UNITS, 1'b0, 40'hB);
      rogue = 1'b0;
      cmd(mtoc_pkg::MTOC_CMD_SET_UNITS, 1'b0, 40'hA);
      chk_val(32'(un_a), 32'hA);
      exp_q.push_back(4'h4);
      cmd(mtoc_pkg::MTOC_CMD_SET_ACQ, 1'b1, 40'h1);
      $display("depth and units test done");
      lfsr = lfsr_next(lfsr);
      r1 = {4'h0, lfsr[27:0]};
      lfsr = lfsr_next(lfsr);
      r2 = r1 + {4'h0, lfsr[27:0]};
      smp(1'b0, r1);
      cmd(mtoc_pkg::MTOC_CMD_CAP_ZERO, 1'b0, 40'h0);
      chk_val(zo_a, r1);
      cmd(mtoc_pkg::MTOC_CMD_SET_ZEN, 1'b0, 40'h1);
      smp(1'b0, r2);
      chk_val(cor_a, r2 - r1);
      cmd(mtoc_pkg::MTOC_CMD_CAP_REF, 1'b0, 40'h0);
      chk_val(ref_a, r2 - r1);
      smp(1'b1, r2);
      cmd(mtoc_pkg::MTOC_CMD_CAP_REF, 1'b1, 40'h0);
      chk_val(ref_b, r2);
      $display("capture test done");
      cmd(mtoc_pkg::MTOC_CMD_SET_ZEN, 1'b0, 40'h0);
      cmd(mtoc_pkg::MTOC_CMD_SET_LVL, 1'b0, 40'h500);
      cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'h2);
      smp(1'b0, 32'h500);
      chk_val(32'(trig), 32'h1);
      smp(1'b0, 32'h4FF);
      chk_val(32'(trig), 32'h0);
      lfsr = lfsr_next(lfsr);
      @(posedge clk);
      en_a <= {20'h0, lfsr[11:0]};
      cmd(mtoc_pkg::MTOC_CMD_SET_ELIM, 1'b0, 40'h1000);
      cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'h3);
      chk_val(32'(trig), 32'h1);
      @(posedge clk);
      en_a <= {20'h1, lfsr[11:0]};
      repeat (3) @(posedge clk);
      #1;
      chk_val(32'(trig), 32'h0);
      cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'h0);
      smp(1'b1, r1);
      chk_val(32'(trig), 32'h1);
      repeat (mtoc_pkg::MTOC_PULSE_CYC - 3) @(posedge clk);
      #1;
      chk_val(32'(trig), 32'h1);
      @(posedge clk);
      #1;
      chk_val(32'(trig), 32'h0);
      // rate mode fires at once on entry, then waits out a whole period
      lfsr = lfsr_next(lfsr);
      cmd(mtoc_pkg::MTOC_CMD_SET_RATE, 1'b0, 40'(lfsr[19:0]));
      cmd(mtoc_pkg::MTOC_CMD_SET_MODE, 1'b0, 40'h1);
      chk_val(32'(trig), 32'h1);
      repeat (mtoc_pkg::MTOC_PULSE_CYC) @(posedge clk);
      #1;
      chk_val(32'(trig), 32'h0);
      chk_val(32'(exp_q.size()), 32'h0);
      $display("trigger test done");
      wrap_up();
   end
endmodule : meter_trigger_output_control_test

// [verification/mtoc_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host model: turns each bench request into a one-cycle strobe
// ------------------------------------------------------------
module mtoc_host_model (
   // clock
   input  wire logic        i_clock,
   // bench request
   input  wire logic        i_go,
   input  wire logic        i_rogue,
   input  wire logic [3:0]  i_code,
   input  wire logic        i_chan,
   input  wire logic [39:0] i_arg,
   // command port
   output logic             o_cmd_valid,
   output logic [3:0]       o_cmd_code,
   output logic             o_cmd_chan,
   output logic [39:0]      o_cmd_arg
);
   logic [39:0] arg_fix;
   // a careful host keeps rate and units legal; rogue lets a refusal through
   assign arg_fix = i_rogue ? i_arg :
      (i_code == mtoc_pkg::MTOC_CMD_SET_RATE && (i_arg == 40'h0 || i_arg > 40'hF4240)) ?
      40'h1 :
      (i_code == mtoc_pkg::MTOC_CMD_SET_UNITS && i_arg > 40'hA) ? 40'hA : i_arg;
   initial o_cmd_valid = 1'b0;
   // idle lines flip every cycle so a stale argument is never mistaken for live
   always @(posedge i_clock) begin
      o_cmd_valid <= i_go;
      o_cmd_code  <= i_go ? i_code : ~o_cmd_code;
      o_cmd_chan  <= i_go ? i_chan : ~o_cmd_chan;
      o_cmd_arg   <= i_go ? arg_fix : ~o_cmd_arg;
   end
endmodule : mtoc_host_model
